// File: mrpu_pkg.sv
// Package for the memory region protection unit: register map, fields and carriers
package mrpu_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [31:0] ADDR_TYPE_INFO = 32'hE000ED90;
   localparam logic [31:0] ADDR_CONTROL = 32'hE000ED94;
   localparam logic [31:0] ADDR_REGION_SELECT = 32'hE000ED98;
   localparam logic [31:0] ADDR_BASE = 32'hE000ED9C;
   localparam logic [31:0] ADDR_ATTR = 32'hE000EDA0;
   localparam logic [31:0] ADDR_BASE_A1 = 32'hE000EDA4;
   localparam logic [31:0] ADDR_ATTR_A1 = 32'hE000EDA8;
   localparam logic [31:0] ADDR_BASE_A2 = 32'hE000EDAC;
   localparam logic [31:0] ADDR_ATTR_A2 = 32'hE000EDB0;
   localparam logic [31:0] ADDR_BASE_A3 = 32'hE000EDB4;
   localparam logic [31:0] ADDR_ATTR_A3 = 32'hE000EDB8;

   // ****************************************************************
   // Reset values and fixed fields
   // ****************************************************************
   localparam logic [31:0] TYPE_INFO_VALUE = 32'h00000800;
   localparam logic [2:0] CONTROL_RESET = 3'h0;
   localparam logic [2:0] REGION_SELECT_RESET = 3'h0;
   localparam logic [31:0] REG_RESET = 32'h00000000;
   localparam int NUM_REGIONS = 8;

   // Control bit positions
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_HIPRIO_BIT = 1;
   localparam int CTL_BGMAP_BIT = 2;

   // Base address register fields
   localparam int BASE_VALID_BIT = 4;
   localparam int BASE_ADDR_LSB = 5;

   // Attribute/size register fields
   localparam int ATTR_ENABLE_BIT = 0;
   localparam int ATTR_SIZE_LSB = 1;
   localparam int ATTR_SRD_LSB = 8;
   localparam int ATTR_B_BIT = 16;
   localparam int ATTR_C_BIT = 17;
   localparam int ATTR_TEX_LSB = 19;
   localparam int ATTR_AP_LSB = 24;
   localparam int ATTR_XN_BIT = 28;
   localparam logic [31:0] ATTR_WRITE_MASK = 32'h173FFF3F;
   localparam logic [4:0] MIN_SIZE_FIELD = 5'h04;

   // ****************************************************************
   // Fixed address windows
   // ****************************************************************
   localparam logic [31:0] SCS_BASE = 32'hE000E000;
   localparam logic [31:0] SCS_LAST = 32'hE000EFFF;
   localparam logic [31:0] VTABLE_LAST = 32'h000003FF;
   // Default map: execute never from 0xA0000000 upward
   localparam logic [31:0] DEFAULT_XN_BASE = 32'hA0000000;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic fetch;
      logic write;
      logic priv;
      logic hi_prio;
   } mrpu_access_t;

   typedef struct packed {
      logic fault;
      logic allowed;
      logic no_exec_region;
      logic [3:0] hit_region;
      logic [2:0] tex;
      logic cache;
      logic buffer;
   } mrpu_result_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
      logic priv;
   } mrpu_bus_t;

endpackage

// File: mrpu_top.sv
// Memory region protection unit: register bank and access checker
`timescale 1ns/10ps

// How it works
// (R1) Eight regions 0..7 plus an optional background region.
// (R2) Overlapping hits use the highest-numbered matching region.
// (R3) Background region uses default attributes, privileged accesses only.
// (R4) Fetches and data accesses check the same region set.
// (R5) Forbidden accesses raise a memory management fault pulse.
// (R6) Type register reads zero instruction regions, eight data regions, unified.
// (R7) Enabled, background off: no region hit means fault.
// (R8) Background acts as region -1 for privileged accesses, lowest priority.
// (R9) Background enable has no effect while protection is disabled.
// (R10) Without high-priority check, handlers at priority -1/-2 bypass regions.
// (R11) High-priority check enable keeps checking at priority -1/-2.
// (R12) Software must not set high-priority check with protection off.
// (R13) Enabled with background: unprivileged miss faults.
// (R14) System control space is always no-execute and strongly ordered.
// (R15) Protection disabled: default map for everyone, no region faults.
// (R16) Protection enabled: vector table always allowed, system control space allowed except for fetches.
// (R17) Alias pairs reach the same base and attribute registers.
// (R18) Base write with valid set loads region select first.
// (R19) Region size is two to the size field plus one; minimum 32 bytes.
// (R20) No-execute regions refuse instruction fetches with a fault.
// (R21) Control holds enable bit 0, high-priority bit 1, background bit 2.
// (R22) Unprivileged register accesses are refused with a bus error.
module mrpu_top
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire mrpu_pkg::mrpu_bus_t bus_req,
   output logic [31:0] bus_rdata,
   output logic bus_error,
   // Access check from the core
   input wire mrpu_pkg::mrpu_access_t acc_req,
   output mrpu_pkg::mrpu_result_t acc_result,
   output logic acc_result_valid
);

   // ****************************************************************
   // Region storage
   // ****************************************************************
   logic [2:0] control_r;
   logic [2:0] region_select_r;
   logic [31:0] base_r [mrpu_pkg::NUM_REGIONS];
   logic [31:0] attr_r [mrpu_pkg::NUM_REGIONS];

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic logic is_base_addr(input logic [31:0] a);
      is_base_addr = (a == mrpu_pkg::ADDR_BASE) || (a == mrpu_pkg::ADDR_BASE_A1)
         || (a == mrpu_pkg::ADDR_BASE_A2) || (a == mrpu_pkg::ADDR_BASE_A3);
   endfunction

   function automatic logic is_attr_addr(input logic [31:0] a);
      is_attr_addr = (a == mrpu_pkg::ADDR_ATTR) || (a == mrpu_pkg::ADDR_ATTR_A1)
         || (a == mrpu_pkg::ADDR_ATTR_A2) || (a == mrpu_pkg::ADDR_ATTR_A3);
   endfunction

   wire sel_type = bus_req.addr == mrpu_pkg::ADDR_TYPE_INFO;
   wire sel_ctl = bus_req.addr == mrpu_pkg::ADDR_CONTROL;
   wire sel_rsel = bus_req.addr == mrpu_pkg::ADDR_REGION_SELECT;
   wire sel_base = is_base_addr(bus_req.addr); // (R17)
   wire sel_attr = is_attr_addr(bus_req.addr); // (R17)
   wire sel_any = sel_type | sel_ctl | sel_rsel | sel_base | sel_attr;
   wire bus_ok = bus_req.priv; // (R22)
   wire wr_ok = bus_req.wr & bus_ok;
   wire base_valid_wr = wr_ok & sel_base & bus_req.wdata[mrpu_pkg::BASE_VALID_BIT];
   // A valid base write retargets the selector and the stored region together
   wire [2:0] wr_region = base_valid_wr ? bus_req.wdata[2:0] : region_select_r; // (R18)
   wire [2:0] rsel_nxt = base_valid_wr ? bus_req.wdata[2:0] // (R18)
      : (wr_ok & sel_rsel) ? bus_req.wdata[2:0] : region_select_r;
   wire [31:0] base_wval = {bus_req.wdata[31:mrpu_pkg::BASE_ADDR_LSB], 5'h00};
   wire [31:0] attr_wval = bus_req.wdata & mrpu_pkg::ATTR_WRITE_MASK;

   // Read data: region field of base reads the selector, valid reads zero
   wire [31:0] base_rd = {base_r[region_select_r][31:mrpu_pkg::BASE_ADDR_LSB],
      2'h0, region_select_r};
   wire [31:0] rd_mux = sel_type ? mrpu_pkg::TYPE_INFO_VALUE // (R6)
      : sel_ctl ? {29'h0, control_r}
      : sel_rsel ? {29'h0, region_select_r}
      : sel_base ? base_rd
      : sel_attr ? attr_r[region_select_r] : 32'h00000000;
   wire [31:0] rdata_nxt = (bus_req.rd & bus_ok) ? rd_mux : 32'h00000000;
   wire berr_nxt = (bus_req.rd | bus_req.wr) & (~bus_ok | ~sel_any); // (R22)

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         control_r <= mrpu_pkg::CONTROL_RESET; // (R21)
         region_select_r <= mrpu_pkg::REGION_SELECT_RESET;
         bus_rdata <= mrpu_pkg::REG_RESET;
         bus_error <= 1'b0;
      end
      else
      begin
         if (wr_ok & sel_ctl)
            control_r <= bus_req.wdata[2:0]; // (R21)
         region_select_r <= rsel_nxt;
         bus_rdata <= rdata_nxt;
         bus_error <= berr_nxt;
      end
   end

   genvar g;
   generate
      for (g = 0; g < mrpu_pkg::NUM_REGIONS; g++)
      begin : g_store
         always_ff @(posedge clk)
         begin
            if (!rst_b)
            begin
               base_r[g] <= mrpu_pkg::REG_RESET;
               attr_r[g] <= mrpu_pkg::REG_RESET;
            end
            else
            begin
               if (wr_ok & sel_base & (wr_region == 3'(g)))
                  base_r[g] <= base_wval;
               if (wr_ok & sel_attr & (region_select_r == 3'(g)))
                  attr_r[g] <= attr_wval;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Region match
   // ****************************************************************
   // Size field s covers 2^(s+1) bytes; fields below 4 are clamped to 32 bytes
   function automatic logic region_hit(input logic [31:0] base, input logic [31:0] attr,
      input logic [31:0] a);
      logic [4:0] sz;
      logic [31:0] mask;
      logic [2:0] sub;
      sz = attr[mrpu_pkg::ATTR_SIZE_LSB +: 5];
      if (sz < mrpu_pkg::MIN_SIZE_FIELD)
         sz = mrpu_pkg::MIN_SIZE_FIELD; // (R19)
      mask = (sz == 5'h1F) ? 32'h00000000 : (32'hFFFFFFFF << (6'(sz) + 6'h01)); // (R19)
      // Subregions are eighths of the region, only above 128 bytes
      sub = (sz >= 5'h07) ? 3'(a >> (6'(sz) - 6'h02)) : 3'h0;
      region_hit = attr[mrpu_pkg::ATTR_ENABLE_BIT] && ((a & mask) == (base & mask))
         && !((sz >= 5'h07) && attr[mrpu_pkg::ATTR_SRD_LSB + sub]);
   endfunction

   // Access permission check from the AP field
   function automatic logic ap_permits(input logic [2:0] ap, input logic priv,
      input logic write);
      case (ap)
         3'h1: ap_permits = priv;
         3'h2: ap_permits = priv | ~write;
         3'h3: ap_permits = 1'b1;
         3'h5: ap_permits = priv & ~write;
         3'h6, 3'h7: ap_permits = ~write;
         default: ap_permits = 1'b0;
      endcase
   endfunction

   logic [mrpu_pkg::NUM_REGIONS-1:0] hit_vec;
   generate
      for (g = 0; g < mrpu_pkg::NUM_REGIONS; g++)
      begin : g_match
         // One region set serves fetches and data alike
         assign hit_vec[g] = region_hit(base_r[g], attr_r[g], acc_req.addr); // (R1) (R4)
      end
   endgenerate

   // Highest number wins where regions overlap
   logic [2:0] win_idx;
   always_comb
   begin
      win_idx = 3'h0;
      for (int i = 0; i < mrpu_pkg::NUM_REGIONS; i++)
         if (hit_vec[i])
            win_idx = 3'(i); // (R2)
   end

   wire any_hit = |hit_vec;
   wire [31:0] win_attr = attr_r[win_idx];
   wire prot_en = control_r[mrpu_pkg::CTL_ENABLE_BIT];
   wire hiprio_en = control_r[mrpu_pkg::CTL_HIPRIO_BIT];
   wire bg_en = control_r[mrpu_pkg::CTL_BGMAP_BIT] & prot_en; // (R9)
   wire in_scs = (acc_req.addr >= mrpu_pkg::SCS_BASE) && (acc_req.addr <= mrpu_pkg::SCS_LAST);
   wire in_vtab = acc_req.addr <= mrpu_pkg::VTABLE_LAST;
   wire default_xn = acc_req.addr >= mrpu_pkg::DEFAULT_XN_BASE;
   // High-priority handlers skip checking unless software asked otherwise
   wire checking = prot_en & ~(acc_req.hi_prio & ~hiprio_en); // (R10) (R11) (R15)
   wire scs_fetch = acc_req.fetch & in_scs; // (R14)

   // ****************************************************************
   // Verdict
   // ****************************************************************
   logic region_fault;
   logic use_region;
   always_comb
   begin
      region_fault = 1'b0;
      use_region = 1'b0;
      if (checking & ~in_scs & ~in_vtab) // (R16)
      begin
         if (any_hit)
         begin
            use_region = 1'b1;
            region_fault = ~ap_permits(win_attr[mrpu_pkg::ATTR_AP_LSB +: 3],
               acc_req.priv, acc_req.write)
               | (acc_req.fetch & win_attr[mrpu_pkg::ATTR_XN_BIT]); // (R20)
         end
         else if (bg_en & acc_req.priv)
            region_fault = acc_req.fetch & default_xn; // (R3) (R8)
         else
            region_fault = 1'b1; // (R7) (R13)
      end
      else if (acc_req.fetch & default_xn)
         region_fault = 1'b1; // (R15)
   end

   wire fault_nxt = acc_req.valid & (region_fault | scs_fetch); // (R5) (R14)
   mrpu_pkg::mrpu_result_t res_nxt;
   always_comb
   begin
      res_nxt.fault = fault_nxt;
      res_nxt.allowed = acc_req.valid & ~fault_nxt;
      res_nxt.no_exec_region = use_region & win_attr[mrpu_pkg::ATTR_XN_BIT];
      res_nxt.hit_region = use_region ? {1'b0, win_idx} : 4'hF;
      // System control space is always strongly ordered
      res_nxt.tex = (use_region & ~in_scs) ? win_attr[mrpu_pkg::ATTR_TEX_LSB +: 3] : 3'h0;
      res_nxt.cache = use_region & ~in_scs & win_attr[mrpu_pkg::ATTR_C_BIT]; // (R14)
      res_nxt.buffer = use_region & ~in_scs & win_attr[mrpu_pkg::ATTR_B_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         acc_result <= '0;
         acc_result_valid <= 1'b0;
      end
      else
      begin
         acc_result <= res_nxt;
         acc_result_valid <= acc_req.valid;
      end
   end

endmodule // mrpu_top

// File: mrpu_monitor.sv
// Port checker for the protection unit
`timescale 1ns/10ps
module mrpu_monitor
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Watched ports
   input wire mrpu_pkg::mrpu_bus_t bus_req,
   input wire logic [31:0] bus_rdata,
   input wire logic bus_error,
   input wire mrpu_pkg::mrpu_access_t acc_req,
   input wire mrpu_pkg::mrpu_result_t acc_result,
   input wire logic acc_result_valid
);
   logic [2:0] ctl_r;
   wire ctl_wr = bus_req.wr && bus_req.priv && bus_req.addr == mrpu_pkg::ADDR_CONTROL;
   wire in_scs = acc_req.addr >= mrpu_pkg::SCS_BASE && acc_req.addr <= mrpu_pkg::SCS_LAST;
   wire dat = acc_req.valid && !acc_req.fetch;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Shadow of the control bits, so each check knows the mode in force
   always_ff @(posedge clk)
      if (!rst_b) ctl_r <= 3'h0;
      else if (ctl_wr) ctl_r <= bus_req.wdata[2:0];
   a_result_one_late: assert property (acc_req.valid |=> acc_result_valid)
      else $error("result valid missing");
   a_no_stray_result: assert property (!acc_req.valid
      |=> !acc_result_valid && !acc_result.fault)
      else $error("result without request");
   a_verdict_excl: assert property (acc_req.valid |=> acc_result.allowed != acc_result.fault)
      else $error("allowed and fault disagree");
   a_off_no_fault: assert property (dat && !ctl_r[0] |=> !acc_result.fault)
      else $error("fault while disabled");
   a_bg_ignored_off: assert property (dat && ctl_r == 3'h4 |=> !acc_result.fault)
      else $error("background bit acted while disabled");
   a_handler_bypass: assert property (dat && ctl_r[0] && !ctl_r[1] && acc_req.hi_prio
      |=> !acc_result.fault)
      else $error("fault in bypassed handler");
   a_scs_no_exec: assert property (acc_req.valid && acc_req.fetch && in_scs
      |=> acc_result.fault)
      else $error("fetch from control space allowed");
   a_scs_ordered: assert property (acc_req.valid && in_scs
      |=> acc_result.tex == 3'h0 && !acc_result.cache && !acc_result.buffer)
      else $error("control space not strongly ordered");
   a_fixed_allowed: assert property (dat && ctl_r[0]
      && (in_scs || acc_req.addr <= mrpu_pkg::VTABLE_LAST) |=> !acc_result.fault)
      else $error("control space or vectors faulted");
   a_type_read: assert property (bus_req.rd && bus_req.priv
      && bus_req.addr == mrpu_pkg::ADDR_TYPE_INFO |=> bus_rdata == mrpu_pkg::TYPE_INFO_VALUE)
      else $error("type register value");
   a_ctrl_read: assert property (bus_req.rd && bus_req.priv
      && bus_req.addr == mrpu_pkg::ADDR_CONTROL |=> bus_rdata == {29'h0, ctl_r})
      else $error("control readback");
   a_unpriv_refused: assert property ((bus_req.rd || bus_req.wr) && !bus_req.priv
      |=> bus_error && bus_rdata == 32'h0)
      else $error("unprivileged access not refused");
   a_error_cause: assert property (!bus_req.rd && !bus_req.wr |=> !bus_error)
      else $error("bus error without access");
endmodule // mrpu_monitor

// File: mrpu_core_model.sv
// Core side model that issues access checks
`timescale 1ns/10ps
module mrpu_core_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bench request and access bus
   input wire mrpu_pkg::mrpu_access_t issue,
   output mrpu_pkg::mrpu_access_t acc_req
);
   // Idle cycles flip the address so a stale value is never mistaken for a request
   always_ff @(posedge clk)
      if (!rst_b) acc_req <= '0;
      else if (issue.valid) acc_req <= issue;
      else
      begin
         acc_req.valid <= 1'b0;
         acc_req.addr <= ~acc_req.addr;
      end
endmodule // mrpu_core_model

// File: tb_mrpu_top.sv
// Testbench for the memory region protection unit
`timescale 1ns/10ps
module tb_mrpu_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   mrpu_pkg::mrpu_bus_t bus_req = '0;
   mrpu_pkg::mrpu_access_t issue = '0;
   mrpu_pkg::mrpu_access_t acc_req;
   mrpu_pkg::mrpu_result_t acc_result;
   logic [31:0] bus_rdata;
   logic bus_error;
   logic acc_result_valid;
   logic [2:0] ctl = 3'h0;
   logic [15:0] lf = 16'h0009;
   int error_cnt = 0;
   int n_tests = 0;
   // High-priority check is never set with protection off
   logic [2:0] modes [6] = '{3'h1, 3'h3, 3'h5, 3'h7, 3'h4, 3'h0};
   logic [31:0] addrs [9] = '{32'h20000100, 32'h20000010, 32'h2000001F, 32'h20000020,
      32'h00008010, 32'h30000000, 32'h00000100, 32'hE000E100, 32'hA0000000};
   always #2 clk = ~clk;
   mrpu_top dut (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .bus_error(bus_error), .acc_req(acc_req), .acc_result(acc_result),
      .acc_result_valid(acc_result_valid));
   mrpu_core_model core (.clk(clk), .rst_b(rst_b), .issue(issue), .acc_req(acc_req));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Regions: 0 at 20000000 64KB open, 1 at E0000000 64KB open over the control space,
   // 3 at 8000 1KB privileged and no-execute,
   // 7 at 20000000 32B with no access
   function automatic logic exp_fault(input logic [31:0] a, input logic f, p, h);
      logic scs;
      scs = a >= mrpu_pkg::SCS_BASE && a <= mrpu_pkg::SCS_LAST;
      if (f && scs) return 1'b1;
      if (!ctl[0] || (h && !ctl[1])) return f && a >= mrpu_pkg::DEFAULT_XN_BASE;
      if (scs || a <= mrpu_pkg::VTABLE_LAST) return 1'b0;
      if (a[31:5] == 27'h1000000) return 1'b1;
      if (a[31:10] == 22'h000020) return f || !p;
      if (a[31:16] == 16'h2000) return 1'b0;
      if (ctl[2] && p) return f && a >= mrpu_pkg::DEFAULT_XN_BASE;
      return 1'b1;
   endfunction
   task automatic complete_run();
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp32(input logic [31:0] got, exp, input string m);
      n_tests++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %0t %s", $time, m);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [31:0] a, d, input logic p = 1'b1);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, priv: p};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, exp, input logic p, e);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1, priv: p};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      cmp32(bus_rdata, exp, "read data");
      cmp32({31'h0, bus_error}, {31'h0, e}, "bus error flag");
   endtask
   task automatic set_ctl(input logic [2:0] c);
      ctl = c;
      wr(mrpu_pkg::ADDR_CONTROL, {29'h0, c});
   endtask
   task automatic setup(input int r, input logic [31:0] b, at);
      logic [31:0] off;
      off = 32'(8 * (r % 4));
      wr(mrpu_pkg::ADDR_BASE + off, b | 32'h10 | 32'(r));
      wr(mrpu_pkg::ADDR_ATTR + off, at);
      rd(mrpu_pkg::ADDR_REGION_SELECT, 32'(r), 1'b1, 1'b0);
      rd(mrpu_pkg::ADDR_ATTR, at, 1'b1, 1'b0);
      rd(mrpu_pkg::ADDR_BASE + off, b | 32'(r), 1'b1, 1'b0);
   endtask
   task automatic acc(input logic [31:0] a, input logic f, p, h);
      @(posedge clk);
      issue <= '{valid: 1'b1, addr: a, fetch: f, write: p, priv: p, hi_prio: h};
      @(posedge clk);
      issue.valid <= 1'b0;
      repeat (4) if (acc_result_valid !== 1'b1) @(posedge clk) #1;
      if (acc_result_valid !== 1'b1)
      begin
         cmp32(32'h0, 32'h1, "no access result");
         complete_run();
      end
      else
      begin
         cmp32({31'h0, acc_result.fault}, {31'h0, exp_fault(a, f, p, h)}, "fault flag");
         cmp32({31'h0, acc_result.allowed}, {31'h0, ~exp_fault(a, f, p, h)}, "allowed");
      end
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      for (int k = 0; k < 11; k++)
         rd(mrpu_pkg::ADDR_TYPE_INFO + 32'(4 * k), k == 0 ? 32'h00000800 : 32'h0,
            1'b1, 1'b0);
      rd(32'hE000EDBC, 32'h0, 1'b1, 1'b1);
      rd(mrpu_pkg::ADDR_TYPE_INFO, 32'h0, 1'b0, 1'b1);
      wr(mrpu_pkg::ADDR_CONTROL, 32'h7, 1'b0);
      rd(mrpu_pkg::ADDR_CONTROL, 32'h0, 1'b1, 1'b0);
      setup(0, 32'h20000000, 32'h0303001F);
      setup(1, 32'hE0000000, 32'h0303001F);
      setup(2, 32'h60000000, 32'h0);
      setup(3, 32'h00008000, 32'h11000013);
      setup(7, 32'h20000000, 32'h00000009);
      set_ctl(3'h1);
      acc(32'h20000010, 1'b0, 1'b1, 1'b0);
      cmp32({28'h0, acc_result.hit_region}, 32'h7, "overlap winner");
      acc(32'h20000100, 1'b0, 1'b1, 1'b0);
      cmp32({27'h0, acc_result.tex, acc_result.cache, acc_result.buffer}, 32'h3,
         "region attributes");
      acc(32'hE000E100, 1'b0, 1'b1, 1'b0);
      cmp32({27'h0, acc_result.tex, acc_result.cache, acc_result.buffer}, 32'h0,
         "control space ordering");
      foreach (modes[m])
      begin
         set_ctl(modes[m]);
         foreach (addrs[j])
            for (int k = 0; k < 8; k++)
               acc(addrs[j], k[0], k[1], k[2]);
      end
      for (int n = 0; n < 60; n++)
      begin
         lf = lfsr(lf);
         if (n % 10 == 0) set_ctl(modes[lf[7:4] % 6]);
         acc(addrs[lf[3:0] % 9] ^ {22'h0, lf[15:6]}, lf[0], lf[1], lf[2]);
      end
      // A reset in mid-run must clear control and region settings
      @(posedge clk);
      rst_b <= 1'b0;
      ctl = 3'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(mrpu_pkg::ADDR_CONTROL, 32'h0, 1'b1, 1'b0);
      rd(mrpu_pkg::ADDR_ATTR, 32'h0, 1'b1, 1'b0);
      acc(32'h20000010, 1'b0, 1'b0, 1'b0);
      complete_run();
   end
endmodule // tb_mrpu_top
bind mrpu_top mrpu_monitor mon (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
   .bus_rdata(bus_rdata), .bus_error(bus_error), .acc_req(acc_req),
   .acc_result(acc_result), .acc_result_valid(acc_result_valid));
